// [core/pdse_pkg.sv]
// constants and types shared by the pd status and event block
package pdse_pkg;
  // register offsets on the register port
  localparam logic [7:0] PDSE_OFS_FAIL_RST   = 8'h3c;
  localparam logic [7:0] PDSE_OFS_TOG_RX     = 8'h3d;
  localparam logic [7:0] PDSE_OFS_EVENTS     = 8'h3e;
  // reset values
  localparam logic [7:0] PDSE_RST_FAIL_RST   = 8'h00;
  localparam logic [7:0] PDSE_RST_TOG_RX     = 8'h00;
  localparam logic [7:0] PDSE_RST_EVENTS     = 8'h00;
  localparam logic [7:0] PDSE_RDATA_UNMAPPED = 8'h00;
  // pd_fail_reset_status fields
  localparam int PDSE_B_SOFT_FAIL  = 5;
  localparam int PDSE_B_RETRY_FAIL = 4;
  localparam int PDSE_B_IPWR_HI    = 3;
  localparam int PDSE_B_IPWR_LO    = 2;
  localparam int PDSE_B_SOFT_RX    = 1;
  localparam int PDSE_B_HARD_RX    = 0;
  // toggle_rx_type_status fields
  localparam int PDSE_B_TOG_HI     = 5;
  localparam int PDSE_B_TOG_LO     = 3;
  localparam int PDSE_B_RX_DPRIME  = 2;
  localparam int PDSE_B_RX_PRIME   = 1;
  localparam int PDSE_B_RX_PLAIN   = 0;
  // pd_event_flags fields
  localparam int PDSE_E_OCP_TEMP   = 7;
  localparam int PDSE_E_TOG_DONE   = 6;
  localparam int PDSE_E_SOFT_FAIL  = 5;
  localparam int PDSE_E_RETRY_FAIL = 4;
  localparam int PDSE_E_HARD_SENT  = 3;
  localparam int PDSE_E_ACKED      = 2;
  localparam int PDSE_E_SOFT_RX    = 1;
  localparam int PDSE_E_HARD_RX    = 0;
  // toggle result codes
  localparam logic [2:0] PDSE_TOG_RUNNING = 3'h0;
  localparam logic [2:0] PDSE_TOG_SRC1    = 3'h1;
  localparam logic [2:0] PDSE_TOG_SRC2    = 3'h2;
  localparam logic [2:0] PDSE_TOG_SNK1    = 3'h5;
  localparam logic [2:0] PDSE_TOG_SNK2    = 3'h6;
  localparam logic [2:0] PDSE_TOG_AUDIO   = 3'h7;
  localparam logic [2:0] PDSE_TOG_RESET   = 3'h0;
  // what the toggle logic found when it stopped
  typedef enum logic [2:0] {
    PDSE_FOUND_SRC1,
    PDSE_FOUND_SRC2,
    PDSE_FOUND_SNK1,
    PDSE_FOUND_SNK2,
    PDSE_FOUND_AUDIO
  } pdse_found_e;
  // stop state the toggle logic settles in
  typedef enum logic [2:0] {
    PDSE_STOP_NONE,
    PDSE_SETTLED_SOURCE_CH1,
    PDSE_SETTLED_SOURCE_CH2,
    PDSE_SETTLED_SINK_CH1,
    PDSE_SETTLED_SINK_CH2
  } pdse_stop_e;
endpackage : pdse_pkg

// [core/pdse_sticky.sv]
// vector of sticky flags: set wins over clear
`timescale 1ns/1ps
module pdse_sticky
  import pdse_pkg::*;
#(
  parameter int          W   = 8,
  parameter logic [W-1:0] RST = '0
)(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // set and clear
  input  wire logic [W-1:0] set_i,
  input  wire logic         clr_i,
  // flags
  output logic      [W-1:0] flag_r
);
  logic [W-1:0] flag_nxt;

  always_comb
  begin
    flag_nxt = (clr_i ? '0 : flag_r) | set_i;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_r <= RST;
    else
      flag_r <= flag_nxt;
  end
endmodule : pdse_sticky

// [core/pdse_toggle.sv]
// toggle result tracker: running code, settled code, stop state
`timescale 1ns/1ps
module pdse_toggle
  import pdse_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // from toggle logic
  input  wire logic        toggle_enable,
  input  wire logic        settle_pulse,
  input  wire pdse_found_e settle_kind,
  // results
  output logic [2:0]       toggle_result_code_r,
  output pdse_stop_e       stop_state_r,
  output logic             done_r
);
  typedef enum logic [1:0] {TG_IDLE, TG_RUN, TG_STOP} pdse_tg_e;
  pdse_tg_e   st_r, st_nxt;
  logic [2:0] code_nxt;
  pdse_stop_e stop_nxt;
  logic       done_nxt;

  always_comb
  begin
    st_nxt   = st_r;
    code_nxt = toggle_result_code_r;
    stop_nxt = stop_state_r;
    done_nxt = 1'b0;
    case (st_r)
      TG_IDLE:
        if (toggle_enable)
        begin
          st_nxt   = TG_RUN;
          code_nxt = PDSE_TOG_RUNNING;
          stop_nxt = PDSE_STOP_NONE;
        end
      TG_RUN:
        if (!toggle_enable)
          st_nxt = TG_IDLE;
        else if (settle_pulse)
        begin
          st_nxt   = TG_STOP;
          done_nxt = 1'b1;
          case (settle_kind)
            PDSE_FOUND_SRC1:
            begin
              code_nxt = PDSE_TOG_SRC1;
              stop_nxt = PDSE_SETTLED_SOURCE_CH1;
            end
            PDSE_FOUND_SRC2:
            begin
              code_nxt = PDSE_TOG_SRC2;
              stop_nxt = PDSE_SETTLED_SOURCE_CH2;
            end
            PDSE_FOUND_SNK1:
            begin
              code_nxt = PDSE_TOG_SNK1;
              stop_nxt = PDSE_SETTLED_SINK_CH1;
            end
            PDSE_FOUND_SNK2:
            begin
              code_nxt = PDSE_TOG_SNK2;
              stop_nxt = PDSE_SETTLED_SINK_CH2;
            end
            default:
            begin
              code_nxt = PDSE_TOG_AUDIO;
              stop_nxt = PDSE_SETTLED_SOURCE_CH1;
            end
          endcase
        end
      TG_STOP:
        if (!toggle_enable)
          st_nxt = TG_IDLE;
      default:
        st_nxt = TG_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r                 <= TG_IDLE;
      toggle_result_code_r <= PDSE_TOG_RESET;
      stop_state_r         <= PDSE_STOP_NONE;
      done_r               <= 1'b0;
    end
    else
    begin
      st_r                 <= st_nxt;
      toggle_result_code_r <= code_nxt;
      stop_state_r         <= stop_nxt;
      done_r               <= done_nxt;
    end
  end
endmodule : pdse_toggle

// [core/pdse_status_events.sv]
// pd status and event register bank with read port and event output
// Contract
// - set soft-reset-failed status bit 5 when all soft reset retries fail.
// - set retries-exhausted status bit 4 when all packet retries fail.
// - transmit start, transmitter-on or hard reset send clears bits 5 and 4.
// - show internal power request in bits 3:2; effective power is the higher.
// - set status bit 1 when a soft reset packet was received.
// - set status bit 0 when a hard reset ordered set was received.
// - toggle result field bits 5:3 reads 000 while toggling runs.
// - code 001 source on channel 1, code 010 source on channel 2.
// - code 101 sink on channel 1, code 110 sink on channel 2.
// - code 111 for audio accessory; then settle as source on channel 1.
// - bits 2,1,0 give type of last stored packet: dprime dbg, prime dbg, sop.
// - event bit 7 on vconn over-current or over-temperature; read clears.
// - event bit 6 when toggling ends on attach detection; read clears.
// - event bit 5 when automatic soft reset sequence fails; read clears.
// - event bit 4 when packet retries are exhausted; read clears.
// - event bit 3 after a hard reset ordered set was sent; read clears.
// - event bit 2 when a sent packet got a goodcrc; read clears.
// - event bit 1 on receiving a soft reset packet; read clears.
// - event bit 0 on receiving a hard reset ordered set; read clears.
// - a set mask bit keeps its event flag off the interrupt output.
`timescale 1ns/1ps
module pdse_status_events
  import pdse_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register read port
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  output logic      [7:0]  reg_rdata_r,
  output logic             reg_rvalid_r,
  // transmitter and protocol engine
  input  wire logic        soft_fail_pulse,
  input  wire logic        retry_fail_pulse,
  input  wire logic        start_tx_cmd,
  input  wire logic        transmitter_on_cmd,
  input  wire logic        send_hard_reset_cmd,
  input  wire logic        hard_reset_sent_pulse,
  input  wire logic        packet_acked_pulse,
  input  wire logic        pd_logic_reset,
  // receiver
  input  wire logic        soft_reset_rx_pulse,
  input  wire logic        hard_reset_rx_pulse,
  input  wire logic        rx_pkt_stored,
  input  wire logic [2:0]  rx_pkt_kind,
  // power
  input  wire logic [3:0]  power_enable_field,
  input  wire logic [1:0]  internal_power_request,
  output logic      [3:0]  eff_power_r,
  // protection monitors
  input  wire logic        vconn_ocp_pulse,
  input  wire logic        overtemp_pulse,
  // toggle logic
  input  wire logic        toggle_enable,
  input  wire logic        toggle_settle_pulse,
  input  wire pdse_found_e toggle_settle_kind,
  output pdse_stop_e       toggle_stop_state_r,
  // event mask and interrupt
  input  wire logic [7:0]  event_mask,
  output logic             int_n_r
);
  logic [1:0] fail_set, fail_r;
  logic       fail_clr;
  logic [1:0] rxrst_set, rxrst_r;
  logic [7:0] evt_set, evt_r, evt_nxt;
  logic       evt_clr;
  logic [2:0] toggle_result_code_r;
  logic       tog_done;
  logic [2:0] rx_type_r, rx_type_nxt;
  logic [1:0] ipwr_r, ipwr_nxt;
  logic [3:0] eff_power_nxt, alt_power;
  logic [7:0] fail_rst_view, tog_rx_view;
  logic [7:0] rdata_nxt;
  logic       rvalid_nxt;
  logic       int_n_nxt;

  // failure status bits; set wins over a command in the same cycle
  always_comb
  begin
    fail_set = 2'h0;
    fail_set[1] = soft_fail_pulse;
    fail_set[0] = retry_fail_pulse;
    fail_clr = start_tx_cmd | transmitter_on_cmd | send_hard_reset_cmd;
  end

  pdse_sticky #(
    .W   (2),
    .RST (2'h0)
  ) u_fail (
    .clk    (clk),
    .rst_n  (rst_n),
    .set_i  (fail_set),
    .clr_i  (fail_clr),
    .flag_r (fail_r)
  );

  // received reset status bits, cleared by a pd logic reset
  always_comb
  begin
    rxrst_set    = 2'h0;
    rxrst_set[1] = soft_reset_rx_pulse;
    rxrst_set[0] = hard_reset_rx_pulse;
  end

  pdse_sticky #(
    .W   (2),
    .RST (2'h0)
  ) u_rxrst (
    .clk    (clk),
    .rst_n  (rst_n),
    .set_i  (rxrst_set),
    .clr_i  (pd_logic_reset),
    .flag_r (rxrst_r)
  );

  // toggle progress
  pdse_toggle u_toggle (
    .clk                  (clk),
    .rst_n                (rst_n),
    .toggle_enable        (toggle_enable),
    .settle_pulse         (toggle_settle_pulse),
    .settle_kind          (toggle_settle_kind),
    .toggle_result_code_r (toggle_result_code_r),
    .stop_state_r         (toggle_stop_state_r),
    .done_r               (tog_done)
  );

  // event flags, cleared by a read of the event register
  always_comb
  begin
    evt_set = 8'h00;
    evt_set[PDSE_E_OCP_TEMP]   = vconn_ocp_pulse | overtemp_pulse;
    evt_set[PDSE_E_TOG_DONE]   = tog_done;
    evt_set[PDSE_E_SOFT_FAIL]  = soft_fail_pulse;
    evt_set[PDSE_E_RETRY_FAIL] = retry_fail_pulse;
    evt_set[PDSE_E_HARD_SENT]  = hard_reset_sent_pulse;
    evt_set[PDSE_E_ACKED]      = packet_acked_pulse;
    evt_set[PDSE_E_SOFT_RX]    = soft_reset_rx_pulse;
    evt_set[PDSE_E_HARD_RX]    = hard_reset_rx_pulse;
    evt_clr = reg_rd && (reg_addr == PDSE_OFS_EVENTS);
  end

  pdse_sticky #(
    .W   (8),
    .RST (PDSE_RST_EVENTS)
  ) u_evt (
    .clk    (clk),
    .rst_n  (rst_n),
    .set_i  (evt_set),
    .clr_i  (evt_clr),
    .flag_r (evt_r)
  );

  // packet type, internal power request, effective power, interrupt
  always_comb
  begin
    rx_type_nxt = rx_pkt_stored ? rx_pkt_kind : rx_type_r;
    ipwr_nxt    = internal_power_request;
    alt_power   = {internal_power_request, power_enable_field[1:0]};
    eff_power_nxt = (power_enable_field > alt_power) ?
                    power_enable_field : alt_power;
    // interrupt follows the flags as they will stand after this edge
    evt_nxt     = (evt_clr ? 8'h00 : evt_r) | evt_set;
    int_n_nxt   = ~|(evt_nxt & ~event_mask);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_type_r   <= 3'h0;
      ipwr_r      <= 2'h0;
      eff_power_r <= 4'h0;
      int_n_r     <= 1'b1;
    end
    else
    begin
      rx_type_r   <= rx_type_nxt;
      ipwr_r      <= ipwr_nxt;
      eff_power_r <= eff_power_nxt;
      int_n_r     <= int_n_nxt;
    end
  end

  // read port: data one cycle after the strobe, unmapped reads zero
  always_comb
  begin
    fail_rst_view = PDSE_RST_FAIL_RST;
    fail_rst_view[PDSE_B_SOFT_FAIL]  = fail_r[1];
    fail_rst_view[PDSE_B_RETRY_FAIL] = fail_r[0];
    fail_rst_view[PDSE_B_IPWR_HI:PDSE_B_IPWR_LO] = ipwr_r;
    fail_rst_view[PDSE_B_SOFT_RX]    = rxrst_r[1];
    fail_rst_view[PDSE_B_HARD_RX]    = rxrst_r[0];
    tog_rx_view = PDSE_RST_TOG_RX;
    tog_rx_view[PDSE_B_TOG_HI:PDSE_B_TOG_LO] = toggle_result_code_r;
    tog_rx_view[PDSE_B_RX_DPRIME:PDSE_B_RX_PLAIN] = rx_type_r;
    rvalid_nxt = reg_rd;
    rdata_nxt  = reg_rdata_r;
    if (reg_rd)
    begin
      case (reg_addr)
        PDSE_OFS_FAIL_RST: rdata_nxt = fail_rst_view;
        PDSE_OFS_TOG_RX:   rdata_nxt = tog_rx_view;
        PDSE_OFS_EVENTS:   rdata_nxt = evt_r;
        default:           rdata_nxt = PDSE_RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_r  <= 8'h00;
      reg_rvalid_r <= 1'b0;
    end
    else
    begin
      reg_rdata_r  <= rdata_nxt;
      reg_rvalid_r <= rvalid_nxt;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_SOFT_FAIL_SET: assert property (
    soft_fail_pulse |=> fail_r[1] && evt_r[PDSE_E_SOFT_FAIL])
    else $error("soft reset failure not flagged");

  AST_RETRY_FAIL_SET: assert property (
    retry_fail_pulse |=> fail_r[0] && evt_r[PDSE_E_RETRY_FAIL])
    else $error("retry failure not flagged");

  AST_FAIL_CLEAR: assert property (
    (start_tx_cmd || transmitter_on_cmd || send_hard_reset_cmd)
      && !soft_fail_pulse && !retry_fail_pulse |=> fail_r == 2'h0)
    else $error("failure status not cleared by command");

  AST_FAIL_HOLD: assert property (
    fail_r[1] && !(start_tx_cmd || transmitter_on_cmd
      || send_hard_reset_cmd) |=> fail_r[1])
    else $error("soft failure status dropped without command");

  AST_EFF_POWER: assert property (
    ##1 eff_power_r >= $past(power_enable_field)
      && eff_power_r >= {$past(internal_power_request),
                         $past(power_enable_field[1:0])}
      && (eff_power_r == $past(power_enable_field)
          || eff_power_r[3:2] == $past(internal_power_request))
      && eff_power_r[1:0] == $past(power_enable_field[1:0]))
    else $error("effective power below software request");

  AST_RX_RESET: assert property (
    soft_reset_rx_pulse ##1 !pd_logic_reset[*2] |-> rxrst_r[1])
    else $error("soft reset receipt not held");

  AST_TOG_CODE: assert property (
    toggle_settle_pulse && toggle_settle_kind == PDSE_FOUND_SNK2
      ##1 tog_done |-> toggle_result_code_r == PDSE_TOG_SNK2
      && toggle_stop_state_r == PDSE_SETTLED_SINK_CH2)
    else $error("sink channel 2 code wrong");

  AST_TOG_RUNNING: assert property (
    $rose(toggle_enable) |=> toggle_result_code_r == PDSE_TOG_RUNNING)
    else $error("toggle code not running after enable");

  AST_HARD_RX_SET: assert property (
    hard_reset_rx_pulse |=> rxrst_r[0] && evt_r[PDSE_E_HARD_RX])
    else $error("hard reset receipt not flagged");

  AST_OCP_EVENT: assert property (
    vconn_ocp_pulse || overtemp_pulse |=> evt_r[PDSE_E_OCP_TEMP])
    else $error("over-current or over-temperature event not flagged");

  AST_TOG_DONE_EVT: assert property (
    tog_done |=> evt_r[PDSE_E_TOG_DONE])
    else $error("toggle done event not flagged");

  AST_AUDIO_STOP: assert property (
    toggle_result_code_r == PDSE_TOG_AUDIO
      |-> toggle_stop_state_r == PDSE_SETTLED_SOURCE_CH1)
    else $error("audio accessory not settled as source channel 1");

  AST_RX_TYPE: assert property (
    rx_pkt_stored |=> rx_type_r == $past(rx_pkt_kind))
    else $error("packet type not captured");

  AST_READ_CLEARS: assert property (
    evt_clr ##1 reg_rvalid_r |-> evt_r == $past(evt_set))
    else $error("read did not clear events or lost a new one");

  AST_MASK_GATES: assert property (
    ##1 (int_n_r == 1'b0) == |(evt_r & ~$past(event_mask)))
    else $error("interrupt output disagrees with masked flags");

  COV_READ_EVENTS: cover property (evt_clr ##1 reg_rdata_r != 8'h00);
  COV_SET_AND_CLEAR: cover property (evt_clr && (evt_set != 8'h00));
  COV_TOG_AUDIO: cover property (toggle_result_code_r == PDSE_TOG_AUDIO);
  COV_INT_LOW: cover property (!int_n_r);
  COV_FAIL_SET_CLR: cover property (soft_fail_pulse && fail_clr);
endmodule : pdse_status_events

// [dv/pdse_host_model.sv]
// host model that reads the status and event registers
`timescale 1ns/1ps
module pdse_host_model
(
  // clock
  input  wire logic       clk,
  // register read port
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  input  wire logic [7:0] reg_rdata_r,
  input  wire logic       reg_rvalid_r
);
  initial
  begin
    reg_rd   = 1'b0;
    reg_addr = 8'h00;
  end

  // one read strobe; released address lines carry the inverse value
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    while (reg_rvalid_r !== 1'b1 && n < 4)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    // toggle codes are returned raw and never decoded here
    d = (reg_rvalid_r === 1'b1) ? reg_rdata_r : 8'hxx;
  endtask : rd
endmodule : pdse_host_model

// [dv/pdse_status_events_tb_top.sv]
// self-checking bench for the pd status and event register bank
`timescale 1ns/1ps
module pdse_status_events_tb_top
  import pdse_pkg::*;
;
  typedef struct packed {
    logic [13:0] m;
    logic [7:0]  st;
    logic [7:0]  evf;
  } pdse_row_s;

  logic        clk;
  logic        rst_n;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_rdata_r;
  logic        reg_rvalid_r;
  logic [13:0] ev;
  logic [2:0]  rx_pkt_kind;
  logic [3:0]  power_enable_field;
  logic [3:0]  eff_power_r;
  logic [1:0]  internal_power_request;
  logic        toggle_enable;
  pdse_found_e toggle_settle_kind;
  pdse_stop_e  toggle_stop_state_r;
  logic [7:0]  event_mask;
  logic        int_n_r;
  logic [7:0]  d;
  int          n_fail;
  int          comparisons;
  int          cycles;
  pdse_row_s   rows [8];
  pdse_found_e tk [5];
  logic [2:0]  tc [5];
  pdse_stop_e  ts [5];
  logic [3:0]  pfs [4];
  logic [1:0]  irs [4];
  logic [3:0]  effs [4];

  pdse_status_events dut_u (
    .clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
    .soft_fail_pulse(ev[0]), .retry_fail_pulse(ev[1]),
    .start_tx_cmd(ev[2]), .transmitter_on_cmd(ev[3]),
    .send_hard_reset_cmd(ev[4]), .hard_reset_sent_pulse(ev[5]),
    .packet_acked_pulse(ev[6]), .pd_logic_reset(ev[7]),
    .soft_reset_rx_pulse(ev[8]), .hard_reset_rx_pulse(ev[9]),
    .rx_pkt_stored(ev[10]), .rx_pkt_kind(rx_pkt_kind),
    .power_enable_field(power_enable_field),
    .internal_power_request(internal_power_request),
    .eff_power_r(eff_power_r), .vconn_ocp_pulse(ev[11]),
    .overtemp_pulse(ev[12]), .toggle_enable(toggle_enable),
    .toggle_settle_pulse(ev[13]), .toggle_settle_kind(toggle_settle_kind),
    .toggle_stop_state_r(toggle_stop_state_r), .event_mask(event_mask),
    .int_n_r(int_n_r));

  pdse_host_model host_u (
    .clk(clk), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r));

  always #20 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask : chk

  task automatic rdchk(logic [7:0] a, logic [7:0] exp, string nm);
    host_u.rd(a, d);
    chk(nm, exp, d);
  endtask : rdchk

  // one-cycle pulse on the selected event and command inputs
  task automatic pulse(logic [13:0] m);
    @(posedge clk);
    #1 ev = m;
    @(posedge clk);
    #1 ev = '0;
  endtask : pulse

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    ev = '0;
    rx_pkt_kind = 3'h0;
    power_enable_field = 4'h0;
    internal_power_request = 2'h0;
    toggle_enable = 1'b0;
    toggle_settle_kind = PDSE_FOUND_SRC1;
    event_mask = 8'h00;
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    rows = '{'{14'h0001, 8'h20, 8'h20},
             '{14'h0002, 8'h10, 8'h10},
             '{14'h0020, 8'h00, 8'h08},
             '{14'h0040, 8'h00, 8'h04},
             '{14'h0100, 8'h02, 8'h02},
             '{14'h0200, 8'h01, 8'h01},
             '{14'h0800, 8'h00, 8'h80},
             '{14'h1000, 8'h00, 8'h80}};
    tk = '{PDSE_FOUND_SRC1, PDSE_FOUND_SRC2, PDSE_FOUND_SNK1,
           PDSE_FOUND_SNK2, PDSE_FOUND_AUDIO};
    tc = '{PDSE_TOG_SRC1, PDSE_TOG_SRC2, PDSE_TOG_SNK1, PDSE_TOG_SNK2,
           PDSE_TOG_AUDIO};
    ts = '{PDSE_SETTLED_SOURCE_CH1, PDSE_SETTLED_SOURCE_CH2,
           PDSE_SETTLED_SINK_CH1, PDSE_SETTLED_SINK_CH2,
           PDSE_SETTLED_SOURCE_CH1};
    pfs = '{4'h3, 4'hf, 4'h4, 4'h1};
    irs = '{2'h3, 2'h0, 2'h1, 2'h2};
    effs = '{4'hf, 4'hf, 4'h4, 4'h9};
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      pulse(rows[i].m);
      chk("int_n_r set", 8'h00, {7'h0, int_n_r});
      rdchk(8'h3e, rows[i].evf, "pd_event_flags");
      chk("int_n_r read", 8'h01, {7'h0, int_n_r});
      rdchk(8'h3c, rows[i].st, "pd_fail_reset_status");
      pulse(14'h0084);
    end
    // each command clears both failure bits; a same-cycle set wins
    for (int c = 2; c < 5; c++)
    begin
      pulse(14'h0003);
      rdchk(8'h3c, 8'h30, "fail bits set");
      pulse(14'h0001 << c);
      rdchk(8'h3c, 8'h00, "fail bits cleared");
      rdchk(8'h3e, 8'h30, "fail events");
    end
    pulse(14'h0005);
    rdchk(8'h3c, 8'h20, "set beside clear");
    pulse(14'h0004);
    rdchk(8'h3e, 8'h20, "soft fail event");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      #1 power_enable_field = pfs[i];
      internal_power_request = irs[i];
      repeat (2) @(posedge clk);
      #1;
      chk("eff_power_r", {4'h0, effs[i]},
          {4'h0, eff_power_r});
      rdchk(8'h3c, {4'h0, irs[i], 2'h0}, "power request");
    end
    @(posedge clk);
    #1 power_enable_field = 4'h0;
    internal_power_request = 2'h0;
    for (int j = 0; j < 3; j++)
    begin
      @(posedge clk);
      #1 rx_pkt_kind = 3'h1 << j;
      pulse(14'h0400);
      rdchk(8'h3d, {5'h0, 3'h1 << j}, "rx type");
    end
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      #1 toggle_enable = 1'b1;
      toggle_settle_kind = tk[i];
      repeat (2) @(posedge clk);
      rdchk(8'h3d, {2'h0, PDSE_TOG_RUNNING, 3'h4}, "running");
      pulse(14'h2000);
      rdchk(8'h3d, {2'h0, tc[i], 3'h4}, "toggle code");
      chk("stop state", {5'h0, ts[i]}, {5'h0, toggle_stop_state_r});
      rdchk(8'h3e, 8'h40, "toggle done");
      @(posedge clk);
      #1 toggle_enable = 1'b0;
      repeat (2) @(posedge clk);
    end
    #1 toggle_settle_kind = PDSE_FOUND_SNK1;
    pulse(14'h2000);
    rdchk(8'h3d, {2'h0, PDSE_TOG_AUDIO, 3'h4}, "idle settle");
    rdchk(8'h3e, 8'h00, "idle settle event");
    @(posedge clk);
    #1 event_mask = 8'h01;
    pulse(14'h0200);
    chk("int_n_r masked", 8'h01, {7'h0, int_n_r});
    pulse(14'h0100);
    chk("int_n_r unmasked", 8'h00, {7'h0, int_n_r});
    rdchk(8'h3e, 8'h03, "masked flag held");
    event_mask = 8'h00;
    fork
      host_u.rd(8'h3e, d);
      pulse(14'h0200);
    join
    rdchk(8'h3e, 8'h01, "event at clearing read");
    pulse(14'h0203);
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    chk("int_n_r in reset", 8'h01, {7'h0, int_n_r});
    chk("eff_power_r in reset", 8'h00, {4'h0, eff_power_r});
    #1 rst_n = 1'b1;
    chk("stop after reset", {5'h0, PDSE_STOP_NONE},
        {5'h0, toggle_stop_state_r});
    rdchk(8'h3c, PDSE_RST_FAIL_RST, "reset status");
    rdchk(8'h3d, PDSE_RST_TOG_RX, "reset toggle");
    rdchk(8'h3e, PDSE_RST_EVENTS, "reset events");
    rdchk(8'h3f, PDSE_RDATA_UNMAPPED, "unmapped");
    print_verdict();
  end
endmodule : pdse_status_events_tb_top
